/* dv/bert_asserts.sv */
/*
  Checker for the error meter's register port and run status.
  Assumes it is bound to bit_block_error_meter and sees only its ports.
*/
`timescale 1ns/100ps
module bert_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Status
  input wire logic running
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic start_wr;
  logic stop_wr;
  logic cont;
  logic [31:0] tmo;
  logic [31:0] run_cyc;
  assign start_wr = reg_wr && reg_addr == bert_pkg::OFS_CMD && reg_wdata[bert_pkg::CMD_START];
  assign stop_wr = reg_wr && reg_addr == bert_pkg::OFS_CMD && reg_wdata[bert_pkg::CMD_STOP];
  // Mode and limit are mirrored from writes, so no register read is needed here.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cont <= bert_pkg::CTRL_RESET[bert_pkg::CTRL_CONTINUOUS];
      tmo <= bert_pkg::TIMEOUT_RESET;
    end else if (reg_wr && reg_addr == bert_pkg::OFS_CTRL) begin
      cont <= reg_wdata[bert_pkg::CTRL_CONTINUOUS];
    end else if (reg_wr && reg_addr == bert_pkg::OFS_TIMEOUT) begin
      tmo <= reg_wdata;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run_cyc <= 32'h0;
    end else begin
      run_cyc <= running ? run_cyc + 32'h1 : 32'h0;
    end
  end
  sequence s_stop;
    (stop_wr && running) ##1 (!reg_wr) [*3];
  endsequence
  sequence s_start;
    (start_wr && !stop_wr) ##1 (!reg_wr) [*2];
  endsequence
  chk_start_runs: assert property ((start_wr && !stop_wr) |-> ##2 running)
    else $error("running did not follow a start command");
  chk_single_trig: assert property ((!cont && $rose(running)) |-> $past(start_wr, 2))
    else $error("single mode began without a start command");
  chk_stop_halts: assert property ((stop_wr && running) |-> ##[1:4] !running)
    else $error("run kept going after a stop command");
  chk_stop_cause: assert property (s_stop ##1 (reg_rd && reg_addr == bert_pkg::OFS_STATUS)
    |=> reg_rdata[2:1] == bert_pkg::CAUSE_USER)
    else $error("stop cause is not user after a stop");
  chk_start_clears: assert property (s_start ##1 (reg_rd && reg_addr == bert_pkg::OFS_COUNT)
    |=> reg_rdata <= 32'h1)
    else $error("count not cleared by a start");
  chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data present without a read");
  chk_status_run: assert property ((reg_rd && reg_addr == bert_pkg::OFS_STATUS && running)
    ##1 running |-> reg_rdata[3])
    else $error("status misses the running flag");
  chk_time_limit: assert property ((!cont && tmo != 32'h0 && running)
    |-> run_cyc <= tmo * bert_pkg::MS_CYCLES + 32'h8)
    else $error("run outlasted its time limit");
endmodule
bind bit_block_error_meter bert_asserts bert_asserts_i (.sys_clk, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .running);

/* dv/bert_source.sv */
/*
  Model of the device under test: PRBS9 stream, bit clock, qualify and block strobes.
  Assumes the bench sets its knobs while the bit clock stands still.
*/
`timescale 1ns/100ps
module bert_source (
  // Knobs from the bench
  input wire logic en,
  input wire logic qual_lvl,
  input wire logic gaps,
  input wire logic honor,
  input wire logic blocks,
  input wire logic [1:0] run_kind,
  input wire logic [31:0] err_every,
  // Pins toward the meter
  output logic bit_clk,
  output logic bit_data,
  output logic qualify,
  output logic restart,
  output logic block_done,
  output logic block_bad
);
  logic [8:0] lfsr = 9'h1ff;
  int n = 0;
  task automatic step();
    n++;
    qualify = (gaps && n % 64 >= 48) ? !qual_lvl : qual_lvl;
    if (honor && qualify != qual_lvl) begin
      bit_data = ~bit_data;
    end else begin
      bit_data = lfsr[8];
      lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4]};
      if (run_kind != 2'h0 && n % 512 >= 400 && n % 512 < 440) begin
        bit_data = run_kind[0];
      end else if (err_every != 32'h0 && n % err_every == 0) begin
        bit_data = ~bit_data;
      end
    end
    block_done = blocks && n % 8 == 4;
    block_bad = blocks && n % 24 == 4;
  endtask
  // The clock stands still between measurements; data moves on the falling edge.
  initial begin
    bit_clk = 1'b0;
    bit_data = 1'b0;
    qualify = 1'b0;
    restart = 1'b0;
    block_done = 1'b0;
    block_bad = 1'b0;
    forever begin
      #40;
      if (!en) begin
        n = 0;
      end else begin
        bit_clk = ~bit_clk;
        if (!bit_clk) step();
      end
    end
  end
endmodule

/* dv/tb.sv */
/*
  Self-checking bench for the error meter: register port, bit and block runs.
  Assumes the device model in bert_source and the bound checker.
*/
`timescale 1ns/100ps
module tb;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic sys_clk, resetn, reg_wr, reg_rd, rd_d, running, in_sync;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rnd, err_every;
  logic en, qual_lvl, gaps, honor, blocks;
  logic [1:0] run_kind;
  logic bit_clk, bit_data, qualify, restart, block_done, block_bad;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  int err_total = 0;
  int check_count = 0;
  bit_block_error_meter bit_block_error_meter_i (.sys_clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .bit_clk, .bit_data, .qualify, .restart, .block_done,
    .block_bad, .running, .in_sync);
  bert_source bert_source_i (.en, .qual_lvl, .gaps, .honor, .blocks, .run_kind, .err_every,
    .bit_clk, .bit_data, .qualify, .restart, .block_done, .block_bad);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: read %h, expected %h", $time, seen, want);
    end
  endtask
  // Read data stand for one cycle only, so they are compared in that cycle.
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1) begin
      e = exp_q.pop_front();
      check(reg_rdata & e[63:32], e[31:0] & e[63:32]);
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] w);
    exp_q.push_back({m, w});
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 20000 && running !== 1'b0; i++) @(posedge sys_clk);
    if (i == 20000) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic run(input logic [31:0] ctrl, input logic [31:0] lim, input logic [31:0] errs,
                     input logic [1:0] cause, input logic [31:0] fin_e);
    wr(bert_pkg::OFS_CTRL, ctrl);
    wr(bert_pkg::OFS_MAX_BITS, lim);
    wr(bert_pkg::OFS_MAX_BLOCKS, lim);
    wr(bert_pkg::OFS_MAX_ERRS, errs);
    wr(bert_pkg::OFS_CMD, 32'h1);
    @(posedge sys_clk);
    rd(bert_pkg::OFS_COUNT, 32'hffff_fffe, 32'h0);
    en <= 1'b1;
    wait_idle();
    en <= 1'b0;
    rd(bert_pkg::OFS_STATUS, 32'he, {29'h0, cause, 1'b0});
    rd(bert_pkg::OFS_FIN_COUNT, cause == bert_pkg::CAUSE_COUNT ? ALL : 32'h0, lim);
    rd(bert_pkg::OFS_FIN_ERRS, ALL, fin_e);
  endtask
  initial begin
    {resetn, reg_wr, reg_rd, en, qual_lvl, gaps, honor, blocks, run_kind, reg_addr} = '0;
    reg_wdata = 32'h0;
    err_every = 32'h0;
    void'($urandom(32'hbaf337be));
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(bert_pkg::OFS_CTRL, ALL, bert_pkg::CTRL_RESET);
    rd(bert_pkg::OFS_MAX_BITS, ALL, bert_pkg::MAX_BITS_RESET);
    rd(bert_pkg::OFS_MAX_ERRS, ALL, bert_pkg::MAX_ERRS_RESET);
    rd(bert_pkg::OFS_TIMEOUT, ALL, bert_pkg::TIMEOUT_RESET);
    rd(bert_pkg::OFS_MAX_BLOCKS, ALL, bert_pkg::MAX_BLOCKS_RESET);
    rd(4'hf, ALL, 32'h0);
    rnd = $urandom;
    wr(bert_pkg::OFS_MAX_ERRS, rnd);
    rd(bert_pkg::OFS_MAX_ERRS, ALL, rnd);
    // The qualify pin toggles but must be ignored.
    gaps <= 1'b1;
    run(32'h0, 32'h258, 32'h3e8, bert_pkg::CAUSE_COUNT, 32'h0);
    honor <= 1'b1;
    for (int q = 1; q < 3; q++) begin
      qual_lvl <= (q == 1);
      run(q | 32'h4, 32'h258, 32'h3e8, bert_pkg::CAUSE_COUNT, 32'h0);
    end
    gaps <= 1'b0;
    honor <= 1'b0;
    for (int k = 1; k < 3; k++) begin
      run_kind <= 2'(k);
      run(k << bert_pkg::CTRL_RUN_LSB, 32'h258, 32'h3e8, bert_pkg::CAUSE_COUNT, 32'h0);
    end
    // A run of ones with the filter off must be counted as errors.
    run_kind <= 2'h1;
    run(32'h0, 32'h258, 32'h4, bert_pkg::CAUSE_ERRORS, 32'h4);
    run_kind <= 2'h0;
    err_every <= 32'h25;
    run(32'h0, 32'h7d0, 32'h5, bert_pkg::CAUSE_ERRORS, 32'h5);
    err_every <= 32'h0;
    blocks <= 1'b1;
    run(32'h1 << bert_pkg::CTRL_BLOCK_MODE, 32'h6, 32'h3e8, bert_pkg::CAUSE_COUNT, 32'h2);
    blocks <= 1'b0;
    // Data moves on the falling bit clock edge, so falling-edge sampling still sees one bit per edge.
    run(32'h1 << bert_pkg::CTRL_CLK_FALL, 32'h258, 32'h3e8, bert_pkg::CAUSE_COUNT, 32'h0);
    wr(bert_pkg::OFS_CTRL, 32'h1 << bert_pkg::CTRL_CONTINUOUS);
    wr(bert_pkg::OFS_MAX_BITS, 32'hc8);
    wr(bert_pkg::OFS_CMD, 32'h1);
    en <= 1'b1;
    repeat (7000) @(posedge sys_clk);
    rd(bert_pkg::OFS_FIN_COUNT, ALL, 32'hc8);
    rd(bert_pkg::OFS_STATUS, 32'h18, 32'h18);
    check({30'h0, running, in_sync}, 32'h3);
    wr(bert_pkg::OFS_CMD, 32'h2);
    repeat (2) @(posedge sys_clk);
    rd(bert_pkg::OFS_STATUS, 32'he, {29'h0, bert_pkg::CAUSE_USER, 1'b0});
    en <= 1'b0;
    @(posedge sys_clk);
    final_report();
  end
endmodule

/* hdl/bert_pkg.sv */
/*
  Package for the bit and block error meter: register offsets, field positions, reset values,
  the PRBS reference polynomial, run length and timing counts.
  Assumes a 125 MHz system clock and a plain address/strobe register port.
*/
package bert_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_MAX_BITS = 4'h1;
  localparam logic [3:0] OFS_MAX_ERRS = 4'h2;
  localparam logic [3:0] OFS_TIMEOUT = 4'h3;
  localparam logic [3:0] OFS_CMD = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;
  localparam logic [3:0] OFS_COUNT = 4'h6;
  localparam logic [3:0] OFS_ERRS = 4'h7;
  localparam logic [3:0] OFS_FIN_COUNT = 4'h8;
  localparam logic [3:0] OFS_FIN_ERRS = 4'h9;
  localparam logic [3:0] OFS_MAX_BLOCKS = 4'ha;
  // Control register fields.
  localparam int CTRL_QUAL_LSB = 0;
  localparam int CTRL_RUN_LSB = 2;
  localparam int CTRL_RESTART_EN = 4;
  localparam int CTRL_CONTINUOUS = 5;
  localparam int CTRL_INVERT = 6;
  localparam int CTRL_CLK_FALL = 7;
  localparam int CTRL_BLOCK_MODE = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
  // Command register fields.
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  // Qualify and run-ignore selections.
  localparam logic [1:0] QUAL_UNUSED = 2'h0;
  localparam logic [1:0] QUAL_HIGH = 2'h1;
  localparam logic [1:0] QUAL_LOW = 2'h2;
  localparam logic [1:0] RUN_OFF = 2'h0;
  localparam logic [1:0] RUN_ONES = 2'h1;
  localparam logic [1:0] RUN_ZEROS = 2'h2;
  // Stop causes.
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_USER = 2'h1;
  localparam logic [1:0] CAUSE_COUNT = 2'h2;
  localparam logic [1:0] CAUSE_ERRORS = 2'h3;
  localparam logic [1:0] CAUSE_TIMEOUT = 2'h0;
  // Run detector depth and PRBS9 reference.
  localparam int RUN_LEN = 32;
  localparam int PRBS_W = 9;
  localparam int PRBS_TAP = 4;
  localparam logic [8:0] PRBS_SEED = 9'h1ff;
  localparam int SYNC_BITS = 16;
  // Reset values.
  localparam logic [31:0] MAX_BITS_RESET = 32'h0098_9680;
  localparam logic [31:0] MAX_ERRS_RESET = 32'h0001_86a0;
  localparam logic [31:0] MAX_BLOCKS_RESET = 32'h0001_86a0;
  localparam logic [31:0] TIMEOUT_RESET = 32'h0000_0064;
  // Timeout unit is one millisecond.
  localparam int CLK_MHZ = 125;
  localparam int MS_US = 1000;
  localparam int MS_CYCLES = CLK_MHZ * MS_US;
  // Periodic update of published single-mode results, in microseconds.
  localparam int UPDATE_US = 100;
  localparam int UPDATE_CYCLES = CLK_MHZ * UPDATE_US;
endpackage

/* hdl/bert_res_if.sv */
/*
  Interface carrying the published result words from the meter core to its result store.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/100ps
interface bert_res_if;
  logic wr;
  logic [31:0] count;
  logic [31:0] errs;
  logic [31:0] fin_count;
  logic [31:0] fin_errs;
  modport src (output wr, output count, output errs);
  modport store (input wr, input count, input errs, output fin_count, output fin_errs);
endinterface

/* hdl/bert_result_store.sv */
/*
  Result store: holds the last published counts so they stay readable after a measurement.
  Assumes writes come from the meter core on sys_clk.
*/
`timescale 1ns/100ps
module bert_result_store (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Results
  bert_res_if.store res
);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      res.fin_count <= 32'h0;
      res.fin_errs <= 32'h0;
    end else if (res.wr) begin
      res.fin_count <= res.count;
      res.fin_errs <= res.errs;
    end
  end
endmodule

/* hdl/bit_block_error_meter.sv */
/*
  Bit and block error meter core: qualifies, run-filters and checks a serial stream against a
  PRBS reference, counts bits or blocks and errors, and stops on limits, timeout or user stop.
  Assumes the bit clock, data, qualify, restart and block strobes arrive asynchronously on pins.
*/
// Chosen here: the address map and the strobed register port.
// Summary of operation
// - Qualify option unused: every bit is evaluated, qualify input ignored.
// - Active-low qualify evaluates bits while low; active-high while high.
// - Unqualified bits freeze run detector and PRBS reference; resume later.
// - Run-ignore excludes runs of 32 or more ones or zeros as selected.
// - PRBS reference keeps advancing through ignored runs.
// - Run-ignore adds 32 bits of latency before synchronisation.
// - Restart with run-ignore ends interval at once, dropping the 32 held bits.
// - Qualification precedes run-ignore; unqualified bits never reach the detector.
// - A configurable time limit ends the measurement.
// - Block error rate is faulty blocks over checked blocks.
// - Running checked and error counts are readable during measurement.
// - Stop on block limit, error limit or user stop; record the cause.
// - Final counts stay readable after termination.
// - Continuous mode restarts immediately after any termination except a user stop.
// - Continuous mode shows intermediate results only in the first run.
// - Single mode starts only on trigger and ends without restarting.
// - Single mode refreshes published counts periodically while running.
// - Restart rising edge closes interval; falling edge opens next and resyncs.
// - Partial interval counts add up until a limit is reached or exceeded.
// - Excluded bits do not advance the checked-bit counter.
`timescale 1ns/100ps
module bit_block_error_meter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Link pins from the device under test
  input wire logic bit_clk,
  input wire logic bit_data,
  input wire logic qualify,
  input wire logic restart,
  input wire logic block_done,
  input wire logic block_bad,
  // Status pins
  output logic running,
  output logic in_sync
);
  typedef enum logic [1:0] {IDLE, RUN, HOLD} meas_e;
  meas_e state;
  logic [31:0] ctrl;
  logic [31:0] max_bits;
  logic [31:0] max_errs;
  logic [31:0] max_blocks;
  logic [31:0] timeout_ms;
  logic [1:0] stop_cause;
  logic [31:0] count;
  logic [31:0] errs;
  logic first_run;
  logic [2:0] clk_s, dat_s, qual_s, rst_s, bd_s, bb_s;
  logic clk_edge, rst_rise, rst_fall, blk_evt;
  logic interval_open;
  localparam int RUN_LEN_W = 6;
  logic [RUN_LEN_W-1:0] run_len;
  logic [31:0] dly_data;
  logic [31:0] dly_valid;
  logic [5:0] fill;
  logic [8:0] prbs;
  logic [4:0] sync_cnt;
  logic [31:0] ms_div;
  logic [31:0] ms_cnt;
  logic [31:0] upd_div;
  logic start_req, stop_req;
  logic bit_ok, out_bit, out_valid, mismatch, limit_hit, timed_out, end_meas;
  logic [1:0] next_cause;
  bert_res_if res ();

  // Two flip-flops then an edge stage per pin; only stage 1 and 2 are read by logic.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_s <= 3'h0;
      dat_s <= 3'h0;
      qual_s <= 3'h0;
      rst_s <= 3'h0;
      bd_s <= 3'h0;
      bb_s <= 3'h0;
    end else begin
      clk_s <= {clk_s[1:0], bit_clk};
      dat_s <= {dat_s[1:0], bit_data};
      qual_s <= {qual_s[1:0], qualify};
      rst_s <= {rst_s[1:0], restart};
      bd_s <= {bd_s[1:0], block_done};
      bb_s <= {bb_s[1:0], block_bad};
    end
  end

  // Data and qualify are taken on the chosen bit clock edge.
  assign clk_edge = ctrl[bert_pkg::CTRL_CLK_FALL] ? (clk_s[2] & ~clk_s[1])
                                                  : (~clk_s[2] & clk_s[1]);
  assign rst_rise = ctrl[bert_pkg::CTRL_RESTART_EN] & ~rst_s[2] & rst_s[1];
  assign rst_fall = ctrl[bert_pkg::CTRL_RESTART_EN] & rst_s[2] & ~rst_s[1];
  assign blk_evt = ~bd_s[2] & bd_s[1];

  always_comb begin
    case (ctrl[bert_pkg::CTRL_QUAL_LSB +: 2])
      bert_pkg::QUAL_UNUSED: bit_ok = 1'b1;
      bert_pkg::QUAL_HIGH: bit_ok = qual_s[1];
      bert_pkg::QUAL_LOW: bit_ok = ~qual_s[1];
      default: bit_ok = 1'b1;
    endcase
  end

  // Only qualified bits enter the run detector; nothing moves otherwise.
  logic take;
  assign take = clk_edge & bit_ok & interval_open & (state == RUN);
  logic din;
  assign din = dat_s[1] ^ ctrl[bert_pkg::CTRL_INVERT];
  logic run_on;
  assign run_on = ctrl[bert_pkg::CTRL_RUN_LSB +: 2] != bert_pkg::RUN_OFF;
  logic run_val;
  assign run_val = ctrl[bert_pkg::CTRL_RUN_LSB +: 2] == bert_pkg::RUN_ONES;

  // Run detector: a 32-bit delay line, each bit flagged valid until a long run covers it.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dly_data <= 32'h0;
      dly_valid <= 32'h0;
      fill <= 6'h0;
      run_len <= '0;
    end else if (rst_rise || start_req) begin
      dly_valid <= 32'h0;
      fill <= 6'h0;
      run_len <= '0;
    end else if (take && run_on) begin
      dly_data <= {dly_data[30:0], din};
      if (din == run_val) begin
        run_len <= (run_len == 6'(bert_pkg::RUN_LEN)) ? run_len : run_len + 6'h1;
      end else begin
        run_len <= '0;
      end
      // Once the run reaches 32, all bits of it held in the line are struck out.
      if (din == run_val && run_len >= 6'(bert_pkg::RUN_LEN - 1)) begin
        dly_valid <= 32'h0;
      end else begin
        dly_valid <= {dly_valid[30:0], 1'b1};
      end
      if (fill != 6'(bert_pkg::RUN_LEN)) begin
        fill <= fill + 6'h1;
      end
    end
  end

  always_comb begin
    if (run_on) begin
      out_bit = dly_data[31];
      out_valid = take && fill == 6'(bert_pkg::RUN_LEN) && dly_valid[31];
    end else begin
      out_bit = din;
      out_valid = take;
    end
  end
  logic out_step;
  assign out_step = run_on ? (take && fill == 6'(bert_pkg::RUN_LEN)) : take;

  // PRBS9 reference; self-seeds from received bits until in sync, then free runs per bit.
  logic prbs_fb;
  assign prbs_fb = prbs[8] ^ prbs[bert_pkg::PRBS_TAP];
  assign mismatch = out_valid && in_sync && (out_bit != prbs_fb);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prbs <= bert_pkg::PRBS_SEED;
      sync_cnt <= 5'h0;
      in_sync <= 1'b0;
    end else if (rst_fall || start_req) begin
      sync_cnt <= 5'h0;
      in_sync <= 1'b0;
    end else if (out_step) begin
      if (!in_sync) begin
        prbs <= {prbs[7:0], out_bit};
        sync_cnt <= (out_valid && out_bit == prbs_fb) ? sync_cnt + 5'h1 : 5'h0;
        in_sync <= sync_cnt == 5'(bert_pkg::SYNC_BITS - 1);
      end else begin
        prbs <= {prbs[7:0], prbs_fb};
      end
    end
  end

  // Interval gate for external restart.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      interval_open <= 1'b1;
    end else if (!ctrl[bert_pkg::CTRL_RESTART_EN] || start_req) begin
      interval_open <= 1'b1;
    end else if (rst_rise) begin
      interval_open <= 1'b0;
    end else if (rst_fall) begin
      interval_open <= 1'b1;
    end
  end

  // Register port writes.
  assign start_req = reg_wr && reg_addr == bert_pkg::OFS_CMD && reg_wdata[bert_pkg::CMD_START];
  assign stop_req = reg_wr && reg_addr == bert_pkg::OFS_CMD && reg_wdata[bert_pkg::CMD_STOP];
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= bert_pkg::CTRL_RESET;
      max_bits <= bert_pkg::MAX_BITS_RESET;
      max_errs <= bert_pkg::MAX_ERRS_RESET;
      max_blocks <= bert_pkg::MAX_BLOCKS_RESET;
      timeout_ms <= bert_pkg::TIMEOUT_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        bert_pkg::OFS_CTRL: ctrl <= reg_wdata;
        bert_pkg::OFS_MAX_BITS: max_bits <= reg_wdata;
        bert_pkg::OFS_MAX_ERRS: max_errs <= reg_wdata;
        bert_pkg::OFS_MAX_BLOCKS: max_blocks <= reg_wdata;
        bert_pkg::OFS_TIMEOUT: timeout_ms <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Termination: block mode counts blocks, bit mode counts checked bits.
  logic blk_mode;
  assign blk_mode = ctrl[bert_pkg::CTRL_BLOCK_MODE];
  assign limit_hit = (count >= (blk_mode ? max_blocks : max_bits)) && count != 32'h0;
  assign timed_out = timeout_ms != 32'h0 && ms_cnt >= timeout_ms;
  always_comb begin
    next_cause = bert_pkg::CAUSE_NONE;
    if (stop_req) begin
      next_cause = bert_pkg::CAUSE_USER;
    end else if (errs >= max_errs && errs != 32'h0) begin
      next_cause = bert_pkg::CAUSE_ERRORS;
    end else if (limit_hit) begin
      next_cause = bert_pkg::CAUSE_COUNT;
    end
  end
  assign end_meas = state == RUN && (stop_req || next_cause != bert_pkg::CAUSE_NONE || timed_out);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= IDLE;
      stop_cause <= bert_pkg::CAUSE_NONE;
      first_run <= 1'b1;
    end else begin
      case (state)
        IDLE, HOLD: begin
          if (start_req) begin
            state <= RUN;
            stop_cause <= bert_pkg::CAUSE_NONE;
            first_run <= 1'b1;
          end
        end
        RUN: begin
          if (end_meas) begin
            stop_cause <= next_cause;
            first_run <= 1'b0;
            // A user stop always halts; other causes rerun in continuous mode.
            state <= (ctrl[bert_pkg::CTRL_CONTINUOUS] && !stop_req) ? RUN : HOLD;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Counters clear at every start and every continuous restart.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= 32'h0;
      errs <= 32'h0;
    end else if (start_req || end_meas) begin
      count <= 32'h0;
      errs <= 32'h0;
    end else if (state == RUN && blk_mode) begin
      if (blk_evt) begin
        count <= count + 32'h1;
        errs <= errs + {31'h0, bb_s[1]};
      end
    end else if (state == RUN && out_valid && in_sync) begin
      count <= count + 32'h1;
      errs <= errs + {31'h0, mismatch};
    end
  end

  // Millisecond timebase for the timeout and a periodic publish tick.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ms_div <= 32'h0;
      ms_cnt <= 32'h0;
    end else if (state != RUN || end_meas) begin
      ms_div <= 32'h0;
      ms_cnt <= 32'h0;
    end else if (ms_div == 32'(bert_pkg::MS_CYCLES - 1)) begin
      ms_div <= 32'h0;
      ms_cnt <= ms_cnt + 32'h1;
    end else begin
      ms_div <= ms_div + 32'h1;
    end
  end
  logic upd_tick;
  assign upd_tick = upd_div == 32'(bert_pkg::UPDATE_CYCLES - 1);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      upd_div <= 32'h0;
    end else begin
      upd_div <= upd_tick ? 32'h0 : upd_div + 32'h1;
    end
  end

  // Publish: final values always; intermediate ones in single mode or the first continuous run.
  logic pub_mid;
  assign pub_mid = upd_tick && state == RUN && !end_meas
                   && (!ctrl[bert_pkg::CTRL_CONTINUOUS] || first_run);
  assign res.wr = end_meas || pub_mid;
  assign res.count = count;
  assign res.errs = errs;
  bert_result_store store (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .res(res)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0;
      running <= 1'b0;
    end else begin
      running <= state == RUN;
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          bert_pkg::OFS_CTRL: reg_rdata <= ctrl;
          bert_pkg::OFS_MAX_BITS: reg_rdata <= max_bits;
          bert_pkg::OFS_MAX_ERRS: reg_rdata <= max_errs;
          bert_pkg::OFS_MAX_BLOCKS: reg_rdata <= max_blocks;
          bert_pkg::OFS_TIMEOUT: reg_rdata <= timeout_ms;
          bert_pkg::OFS_STATUS: reg_rdata <= {27'h0, in_sync, state == RUN, stop_cause, 1'b0};
          bert_pkg::OFS_COUNT: reg_rdata <= count;
          bert_pkg::OFS_ERRS: reg_rdata <= errs;
          bert_pkg::OFS_FIN_COUNT: reg_rdata <= res.fin_count;
          bert_pkg::OFS_FIN_ERRS: reg_rdata <= res.fin_errs;
          default: reg_rdata <= 32'h0;
        endcase
      end
    end
  end
endmodule
